// File: rtl/pin_mux_pkg.sv
// Constants, types and behaviour notes for the port pin multiplexer
// Notes on behaviour
// R1: Each pin has its own direction, open-drain, drive, pull-up, wake and function settings.
// R2: The package strap sets which pins exist: A[5:0]; A[7:0] B[3:0] C[3:0]; or A/C[7:0] B[5:0]/[7:0].
// R3: Each port C pin drives an LED at a drive strength selected for that pin alone.
// R4: In alternate-function mode the pin direction comes from the assigned peripheral; here port B pin 3 as clock input follows dir_in.
// R5: A pin's function code is its bit in the low select word over its bit in the high one.
// R6: An enabled crystal oscillator takes port A pins 0 and 1 over any port setting; here their pull-up and wake settings stay in force.
// R7: Port A pins 0 and 6 carry timer input or complementary output as the timer mode says.
// R8: Software writes both select words before setting the function enable.
// R9: On 8-pin parts port A pin 0 takes timer 0 input on code 00, its complement output on 11.
// R10: On 8-pin parts port A pin 1 takes timer 0 output, clock input on 10, analog on 11.
// R11: On 8-pin parts port A pin 2 takes driver enable, reset input on 01, timer 1 output on 10.
// R12: On 8-pin parts port A pin 3 takes clear-to-send, comparator, timer 1 input, analog.
// R13: On 8-pin parts port A pin 4 takes receive data on 00 and negative analog input on 11.
// R14: On 8-pin parts port A pin 5 takes transmit data, timer 1 complement, positive analog.
// R15: With the function enable clear a pin is plain port I/O and its select bits do nothing.
package pin_mux_pkg;
    localparam int NUM_PORTS = 3;
    localparam int PORT_W = 8;
    localparam int DRIVE_W = 2;
    localparam logic [1:0] PKG_8PIN = 2'h0;
    localparam logic [1:0] PKG_20PIN = 2'h1;
    localparam logic [1:0] PKG_28PIN = 2'h2;
    localparam logic [7:0] AVAIL_A_8 = 8'h3f;
    localparam logic [7:0] AVAIL_A_FULL = 8'hff;
    localparam logic [7:0] AVAIL_LOW4 = 8'h0f;
    localparam logic [7:0] AVAIL_B_28_ADC = 8'h3f;
    localparam logic [7:0] AVAIL_NONE = 8'h00;
    localparam logic [1:0] CODE_00 = 2'h0;
    localparam logic [1:0] CODE_01 = 2'h1;
    localparam logic [1:0] CODE_10 = 2'h2;
    localparam logic [1:0] CODE_11 = 2'h3;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [1:0] RESET_DRIVE = 2'h0;

    // Settings of one port, each bit belongs to one pin
    typedef struct packed {
        logic [7:0] out_data;
        logic [7:0] dir_in;
        logic [7:0] open_drain;
        logic [7:0] pull_up;
        logic [7:0] wake_en;
        logic [7:0] alt_function_enable;
        logic [7:0] alt_select_low;
        logic [7:0] alt_select_high;
        logic [15:0] drive;
    } port_cfg_s;

    // Peripheral side signals
    typedef struct packed {
        logic timer0_output;
        logic timer0_output_n;
        logic timer0_in_mode;
        logic timer1_output;
        logic timer1_output_n;
        logic timer1_in_mode;
        logic uart_driver_enable;
        logic uart_transmit_line;
        logic comparator_output;
        logic xtal_enable;
    } periph_out_s;

    typedef struct packed {
        logic timer0_input;
        logic timer1_input;
        logic uart_clear_to_send;
        logic uart_receive_line;
        logic external_clock_input;
        logic ext_reset_n;
    } periph_in_s;
endpackage : pin_mux_pkg

// File: rtl/pin_cfg_bank.sv
// Per-port configuration register bank
`timescale 1ns/1ns
`default_nettype none
module pin_cfg_bank (
    input wire logic CLK_SYS_I,
    input wire logic NRST_I,
    input wire logic wr_en_i,
    input wire pin_mux_pkg::port_cfg_s wr_cfg_i,
    input wire logic [7:0] avail_i,
    output pin_mux_pkg::port_cfg_s cfg_o
);
    wire logic [15:0] drive_mask;

    // Both drive bits follow the presence of their pin
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_mask
            assign drive_mask[2 * gi +: 2] = {2{avail_i[gi]}};
        end
    endgenerate

    // Absent pins hold their reset state
    always_ff @(posedge CLK_SYS_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            cfg_o.out_data <= pin_mux_pkg::RESET_BYTE;
            cfg_o.dir_in <= ~pin_mux_pkg::RESET_BYTE;
            cfg_o.open_drain <= pin_mux_pkg::RESET_BYTE;
            cfg_o.pull_up <= pin_mux_pkg::RESET_BYTE;
            cfg_o.wake_en <= pin_mux_pkg::RESET_BYTE;
            cfg_o.alt_function_enable <= pin_mux_pkg::RESET_BYTE;
            cfg_o.alt_select_low <= pin_mux_pkg::RESET_BYTE;
            cfg_o.alt_select_high <= pin_mux_pkg::RESET_BYTE;
            cfg_o.drive <= {pin_mux_pkg::RESET_BYTE, pin_mux_pkg::RESET_BYTE};
        end
        else if (wr_en_i)
        begin
            cfg_o.out_data <= wr_cfg_i.out_data & avail_i; // see R2
            cfg_o.dir_in <= wr_cfg_i.dir_in | ~avail_i;
            cfg_o.open_drain <= wr_cfg_i.open_drain & avail_i;
            cfg_o.pull_up <= wr_cfg_i.pull_up & avail_i;
            cfg_o.wake_en <= wr_cfg_i.wake_en & avail_i;
            cfg_o.alt_function_enable <= wr_cfg_i.alt_function_enable & avail_i;
            cfg_o.alt_select_low <= wr_cfg_i.alt_select_low & avail_i;
            cfg_o.alt_select_high <= wr_cfg_i.alt_select_high & avail_i;
            cfg_o.drive <= wr_cfg_i.drive & drive_mask; // see R2
        end
    end
endmodule : pin_cfg_bank
`default_nettype wire

// File: rtl/gpio_alternate_function_mux.sv
// Port A-C pin multiplexer with alternate functions
`timescale 1ns/1ns
`default_nettype none
module gpio_alternate_function_mux (
    input wire logic CLK_SYS_I,
    input wire logic NRST_I,
    input wire logic [1:0] PACKAGE_SEL_I,
    input wire logic HAS_ADC_I,
    input wire logic [2:0] CFG_WR_I,
    input wire pin_mux_pkg::port_cfg_s CFG_A_I,
    input wire pin_mux_pkg::port_cfg_s CFG_B_I,
    input wire pin_mux_pkg::port_cfg_s CFG_C_I,
    input wire pin_mux_pkg::periph_out_s PERIPH_I,
    input wire logic [7:0] PIN_A_IN_I,
    input wire logic [7:0] PIN_B_IN_I,
    input wire logic [7:0] PIN_C_IN_I,
    output logic [7:0] PIN_A_OUT_O,
    output logic [7:0] PIN_A_OE_O,
    output logic [7:0] PIN_B_OUT_O,
    output logic [7:0] PIN_B_OE_O,
    output logic [7:0] PIN_C_OUT_O,
    output logic [7:0] PIN_C_OE_O,
    output logic [7:0] PULL_UP_A_O,
    output logic [7:0] PULL_UP_B_O,
    output logic [7:0] PULL_UP_C_O,
    output logic [15:0] LED_DRIVE_C_O,
    output logic [7:0] WAKE_CHANGE_O,
    output logic [7:0] ANALOG_A_O,
    output logic [7:0] PORT_A_DATA_O,
    output logic [7:0] PORT_B_DATA_O,
    output logic [7:0] PORT_C_DATA_O,
    output pin_mux_pkg::periph_in_s PERIPH_O
);
    typedef enum logic [1:0] {PK_8 = 2'h0, PK_20 = 2'h1, PK_28 = 2'h3} pkg_e;

    pkg_e pkg_r;
    logic adc_r;
    logic strap_done_r;
    logic [7:0] avail_a;
    logic [7:0] avail_b;
    logic [7:0] avail_c;
    pin_mux_pkg::port_cfg_s cfg_a;
    pin_mux_pkg::port_cfg_s cfg_b;
    pin_mux_pkg::port_cfg_s cfg_c;
    logic [7:0] a_out;
    logic [7:0] a_oe;
    logic [7:0] a_ana;
    logic [7:0] b_ana;
    logic [7:0] c_ana;
    logic [1:0] code [0:5];
    logic [7:0] a_in_prev_r;
    logic [7:0] b_in_prev_r;
    logic [7:0] c_in_prev_r;

    // Package strap caught once after reset release
    always_ff @(posedge CLK_SYS_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            pkg_r <= PK_8;
            adc_r <= 1'b1;
            strap_done_r <= 1'b0;
        end
        else if (!strap_done_r)
        begin
            strap_done_r <= 1'b1;
            adc_r <= HAS_ADC_I;
            case (PACKAGE_SEL_I)
                pin_mux_pkg::PKG_20PIN: pkg_r <= PK_20;
                pin_mux_pkg::PKG_28PIN: pkg_r <= PK_28;
                default: pkg_r <= PK_8;
            endcase
        end
    end

    // Implemented pins by package
    always_comb
    begin
        case (pkg_r) // see R2
            PK_20:
            begin
                avail_a = pin_mux_pkg::AVAIL_A_FULL;
                avail_b = pin_mux_pkg::AVAIL_LOW4;
                avail_c = pin_mux_pkg::AVAIL_LOW4;
            end
            PK_28:
            begin
                avail_a = pin_mux_pkg::AVAIL_A_FULL;
                avail_b = adc_r ? pin_mux_pkg::AVAIL_B_28_ADC : pin_mux_pkg::AVAIL_A_FULL;
                avail_c = pin_mux_pkg::AVAIL_A_FULL;
            end
            default:
            begin
                avail_a = pin_mux_pkg::AVAIL_A_8;
                avail_b = pin_mux_pkg::AVAIL_NONE;
                avail_c = pin_mux_pkg::AVAIL_NONE;
            end
        endcase
    end

    pin_cfg_bank u_bank_a (
        .CLK_SYS_I(CLK_SYS_I),
        .NRST_I(NRST_I),
        .wr_en_i(CFG_WR_I[0]),
        .wr_cfg_i(CFG_A_I),
        .avail_i(avail_a),
        .cfg_o(cfg_a)
    );
    pin_cfg_bank u_bank_b (
        .CLK_SYS_I(CLK_SYS_I),
        .NRST_I(NRST_I),
        .wr_en_i(CFG_WR_I[1]),
        .wr_cfg_i(CFG_B_I),
        .avail_i(avail_b),
        .cfg_o(cfg_b)
    );
    pin_cfg_bank u_bank_c (
        .CLK_SYS_I(CLK_SYS_I),
        .NRST_I(NRST_I),
        .wr_en_i(CFG_WR_I[2]),
        .wr_cfg_i(CFG_C_I),
        .avail_i(avail_c),
        .cfg_o(cfg_c)
    );

    // Two select bits per pin, one from each word
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++)
        begin : g_code
            assign code[gi] = {cfg_a.alt_select_low[gi], cfg_a.alt_select_high[gi]}; // see R5
        end
    endgenerate

    // Port A output and direction per pin
    always_comb
    begin
        a_out = cfg_a.out_data;
        a_oe = ~cfg_a.dir_in; // see R15
        a_ana = 8'h00;
        if (pkg_r == PK_8)
        begin
            // Pin 0: timer 0 input or complement output
            if (cfg_a.alt_function_enable[0])
            begin
                a_oe[0] = 1'b0;
                if (code[0] == pin_mux_pkg::CODE_11 && !PERIPH_I.timer0_in_mode) // see R9, R7
                begin
                    a_out[0] = PERIPH_I.timer0_output_n;
                    a_oe[0] = 1'b1; // see R4
                end
            end
            if (cfg_a.alt_function_enable[1])
            begin
                a_out[1] = PERIPH_I.timer0_output;
                a_oe[1] = (code[1] == pin_mux_pkg::CODE_00); // see R10
                a_ana[1] = (code[1] == pin_mux_pkg::CODE_11);
            end
            if (cfg_a.alt_function_enable[2])
            begin
                a_out[2] = (code[2] == pin_mux_pkg::CODE_10) ? PERIPH_I.timer1_output
                                                             : PERIPH_I.uart_driver_enable;
                a_oe[2] = (code[2] == pin_mux_pkg::CODE_00) || (code[2] == pin_mux_pkg::CODE_10); // see R11
            end
            if (cfg_a.alt_function_enable[3])
            begin
                a_out[3] = PERIPH_I.comparator_output;
                a_oe[3] = (code[3] == pin_mux_pkg::CODE_01); // see R12
                a_ana[3] = (code[3] == pin_mux_pkg::CODE_11);
            end
            if (cfg_a.alt_function_enable[4])
            begin
                a_oe[4] = 1'b0; // see R13
                a_ana[4] = (code[4] == pin_mux_pkg::CODE_11);
            end
            if (cfg_a.alt_function_enable[5])
            begin
                a_out[5] = (code[5] == pin_mux_pkg::CODE_01) ? PERIPH_I.timer1_output_n
                                                             : PERIPH_I.uart_transmit_line;
                a_oe[5] = (code[5] == pin_mux_pkg::CODE_00) || (code[5] == pin_mux_pkg::CODE_01); // see R14
                a_ana[5] = (code[5] == pin_mux_pkg::CODE_11);
            end
        end
        else
        begin
            // Single function per port A pin
            if (cfg_a.alt_function_enable[0])
            begin
                a_out[0] = PERIPH_I.timer0_output_n;
                a_oe[0] = !PERIPH_I.timer0_in_mode; // see R7
            end
            if (cfg_a.alt_function_enable[1])
            begin
                a_out[1] = PERIPH_I.timer0_output;
                a_oe[1] = 1'b1;
            end
            if (cfg_a.alt_function_enable[2])
            begin
                a_out[2] = PERIPH_I.uart_driver_enable;
                a_oe[2] = 1'b1;
            end
            if (cfg_a.alt_function_enable[3])
                a_oe[3] = 1'b0;
            if (cfg_a.alt_function_enable[4])
                a_oe[4] = 1'b0;
            if (cfg_a.alt_function_enable[5])
            begin
                a_out[5] = PERIPH_I.uart_transmit_line;
                a_oe[5] = 1'b1;
            end
            if (cfg_a.alt_function_enable[6])
            begin
                a_out[6] = PERIPH_I.timer1_output_n;
                a_oe[6] = !PERIPH_I.timer1_in_mode; // see R7
            end
            if (cfg_a.alt_function_enable[7])
            begin
                a_out[7] = PERIPH_I.timer1_output;
                a_oe[7] = 1'b1;
            end
        end
        if (PERIPH_I.xtal_enable)
        begin
            a_oe[1:0] = 2'h0; // see R6
            a_ana[1:0] = 2'h0;
        end
        a_oe = a_oe & avail_a & ~a_ana;
    end

    // Ports B and C: alternate use is analog, besides the clock input on port B pin 3
    assign b_ana = cfg_b.alt_function_enable & cfg_b.alt_select_low & avail_b;
    assign c_ana = cfg_c.alt_function_enable & cfg_c.alt_select_low & avail_c;

    // Open-drain drives only the low level
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_pins
            always_ff @(posedge CLK_SYS_I or negedge NRST_I)
            begin
                if (!NRST_I)
                begin
                    PIN_A_OUT_O[gi] <= 1'b0;
                    PIN_A_OE_O[gi] <= 1'b0;
                    PIN_B_OUT_O[gi] <= 1'b0;
                    PIN_B_OE_O[gi] <= 1'b0;
                    PIN_C_OUT_O[gi] <= 1'b0;
                    PIN_C_OE_O[gi] <= 1'b0;
                end
                else
                begin
                    PIN_A_OUT_O[gi] <= a_out[gi]; // see R1
                    PIN_A_OE_O[gi] <= a_oe[gi] && !(cfg_a.open_drain[gi] && a_out[gi]);
                    PIN_B_OUT_O[gi] <= cfg_b.out_data[gi];
                    PIN_B_OE_O[gi] <= !cfg_b.dir_in[gi] && !b_ana[gi] && avail_b[gi]
                                      && !(cfg_b.open_drain[gi] && cfg_b.out_data[gi]);
                    PIN_C_OUT_O[gi] <= cfg_c.out_data[gi];
                    PIN_C_OE_O[gi] <= !cfg_c.dir_in[gi] && !c_ana[gi] && avail_c[gi]
                                      && !(cfg_c.open_drain[gi] && cfg_c.out_data[gi]);
                end
            end
        end
    endgenerate

    // Side outputs, inputs and change detect
    always_ff @(posedge CLK_SYS_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            PULL_UP_A_O <= 8'h00;
            PULL_UP_B_O <= 8'h00;
            PULL_UP_C_O <= 8'h00;
            LED_DRIVE_C_O <= 16'h0000;
            ANALOG_A_O <= 8'h00;
            PORT_A_DATA_O <= 8'h00;
            PORT_B_DATA_O <= 8'h00;
            PORT_C_DATA_O <= 8'h00;
            WAKE_CHANGE_O <= 8'h00;
            a_in_prev_r <= 8'h00;
            b_in_prev_r <= 8'h00;
            c_in_prev_r <= 8'h00;
            PERIPH_O <= '0;
        end
        else
        begin
            PULL_UP_A_O <= cfg_a.pull_up;
            PULL_UP_B_O <= cfg_b.pull_up;
            PULL_UP_C_O <= cfg_c.pull_up;
            LED_DRIVE_C_O <= cfg_c.drive; // see R3
            ANALOG_A_O <= a_ana;
            PORT_A_DATA_O <= PIN_A_IN_I & avail_a;
            PORT_B_DATA_O <= PIN_B_IN_I & avail_b;
            PORT_C_DATA_O <= PIN_C_IN_I & avail_c;
            a_in_prev_r <= PIN_A_IN_I;
            b_in_prev_r <= PIN_B_IN_I;
            c_in_prev_r <= PIN_C_IN_I;
            WAKE_CHANGE_O <= {5'h00,
                |((PIN_C_IN_I ^ c_in_prev_r) & cfg_c.wake_en & avail_c),
                |((PIN_B_IN_I ^ b_in_prev_r) & cfg_b.wake_en & avail_b),
                |((PIN_A_IN_I ^ a_in_prev_r) & cfg_a.wake_en & avail_a)};
            PERIPH_O.timer0_input <= cfg_a.alt_function_enable[0] && !PERIPH_I.xtal_enable
                && (pkg_r != PK_8 || code[0] == pin_mux_pkg::CODE_00) && PIN_A_IN_I[0];
            PERIPH_O.timer1_input <= (pkg_r == PK_8)
                ? (cfg_a.alt_function_enable[3] && code[3] == pin_mux_pkg::CODE_10 && PIN_A_IN_I[3])
                : (cfg_a.alt_function_enable[6] && PIN_A_IN_I[6]);
            PERIPH_O.uart_clear_to_send <= cfg_a.alt_function_enable[3]
                && (pkg_r != PK_8 || code[3] == pin_mux_pkg::CODE_00) && PIN_A_IN_I[3];
            PERIPH_O.uart_receive_line <= cfg_a.alt_function_enable[4]
                && (pkg_r != PK_8 || code[4] == pin_mux_pkg::CODE_00) && PIN_A_IN_I[4];
            PERIPH_O.external_clock_input <= (pkg_r == PK_8)
                ? (cfg_a.alt_function_enable[1] && !PERIPH_I.xtal_enable
                   && code[1] == pin_mux_pkg::CODE_10 && PIN_A_IN_I[1])
                : (cfg_b.alt_function_enable[3] && !cfg_b.alt_select_low[3] && PIN_B_IN_I[3]);
            PERIPH_O.ext_reset_n <= !((pkg_r == PK_8) && cfg_a.alt_function_enable[2]
                && code[2] == pin_mux_pkg::CODE_01 && !PIN_A_IN_I[2]);
        end
    end

    a_xtal_override: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I) // see R6
        PERIPH_I.xtal_enable |=> PIN_A_OE_O[1:0] == 2'h0)
        else $error("crystal pins driven");
    a_plain_dir: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I) // see R15
        (!cfg_a.alt_function_enable[2] && !cfg_a.dir_in[2] && !cfg_a.open_drain[2]
         && avail_a[2]) |=> PIN_A_OE_O[2] && PIN_A_OUT_O[2] == $past(cfg_a.out_data[2]))
        else $error("plain pin not driven");
    a_pin0_comp: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I) // see R9
        (pkg_r == PK_8 && cfg_a.alt_function_enable[0] && code[0] == pin_mux_pkg::CODE_11
         && !PERIPH_I.timer0_in_mode && !PERIPH_I.xtal_enable && !cfg_a.open_drain[0])
        |=> PIN_A_OE_O[0] && PIN_A_OUT_O[0] == $past(PERIPH_I.timer0_output_n))
        else $error("pin0 complement missing");
    a_pin1_clock: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I) // see R10
        (pkg_r == PK_8 && cfg_a.alt_function_enable[1] && code[1] == pin_mux_pkg::CODE_10)
        |=> !PIN_A_OE_O[1])
        else $error("clock input pin driven");
    a_pin2_timer: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I) // see R11
        (pkg_r == PK_8 && cfg_a.alt_function_enable[2] && code[2] == pin_mux_pkg::CODE_10
         && !cfg_a.open_drain[2]) |=> PIN_A_OE_O[2] && PIN_A_OUT_O[2] == $past(PERIPH_I.timer1_output))
        else $error("pin2 timer output wrong");
    a_pin3_comp: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I) // see R12
        (pkg_r == PK_8 && cfg_a.alt_function_enable[3] && code[3] == pin_mux_pkg::CODE_01
         && !cfg_a.open_drain[3]) |=> PIN_A_OE_O[3] && PIN_A_OUT_O[3] == $past(PERIPH_I.comparator_output))
        else $error("comparator output wrong");
    a_pin4_analog: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I) // see R13
        (pkg_r == PK_8 && cfg_a.alt_function_enable[4] && code[4] == pin_mux_pkg::CODE_11)
        |=> ANALOG_A_O[4] && !PIN_A_OE_O[4])
        else $error("pin4 analog missing");
    a_pin5_tx: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I) // see R14
        (pkg_r == PK_8 && cfg_a.alt_function_enable[5] && code[5] == pin_mux_pkg::CODE_00
         && !cfg_a.open_drain[5]) |=> PIN_A_OE_O[5] && PIN_A_OUT_O[5] == $past(PERIPH_I.uart_transmit_line))
        else $error("transmit line wrong");
    a_absent_pins: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I) // see R2
        (pkg_r == PK_8) |=> PIN_A_OE_O[7:6] == 2'h0 && PIN_B_OE_O == 8'h00 && PIN_C_OE_O == 8'h00)
        else $error("absent pin driven");
endmodule : gpio_alternate_function_mux
`default_nettype wire

// File: test/periph_board_model.sv
// Peripheral and board model for the pin multiplexer
`timescale 1ns/1ns
`default_nettype none
module periph_board_model (
    input wire logic phase_i,
    input wire logic tmode_i,
    input wire logic xtal_i,
    input wire logic [23:0] out_i,
    input wire logic [23:0] oe_i,
    input wire logic [23:0] pu_i,
    output var pin_mux_pkg::periph_out_s per_o,
    output logic [23:0] pin_o
);
    // Peripheral outputs flip with each phase so a stuck route shows
    always_comb
    begin
        per_o = {10{phase_i}} ^ 10'h2aa;
        per_o.timer0_in_mode = tmode_i;
        per_o.timer1_in_mode = 1'b0;
        per_o.xtal_enable = xtal_i;
    end
    // Undriven lines show a shifting pattern unless pulled up
    assign pin_o = (oe_i & out_i) | (~oe_i & (pu_i | ({24{phase_i}} ^ 24'h5a5a5a)));
endmodule : periph_board_model
`default_nettype wire

// File: test/tb_top.sv
// Self-checking testbench for the pin multiplexer
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic clk;
    logic nrst;
    logic phase;
    logic tmode;
    logic xtal;
    logic has_adc;
    logic [1:0] pkg_sel;
    logic [2:0] wr;
    pin_mux_pkg::port_cfg_s cfg_a, cfg_b, cfg_c;
    pin_mux_pkg::periph_out_s per;
    pin_mux_pkg::periph_in_s fn_in;
    logic [23:0] pin_lvl, pout, poe, ppu;
    logic [15:0] led;
    logic [7:0] ana;
    logic [7:0] wake;
    logic [23:0] pdat;
    logic [6:0] fsrc;
    logic [5:0] isrc;
    int bad_count = 0;
    int n_checks = 0;

    assign fsrc = {per.timer1_output_n, per.uart_transmit_line, per.comparator_output,
        per.timer1_output, per.uart_driver_enable, per.timer0_output, per.timer0_output_n};
    assign isrc = {fn_in.uart_receive_line, fn_in.timer1_input, fn_in.uart_clear_to_send,
        fn_in.ext_reset_n, fn_in.external_clock_input, fn_in.timer0_input};

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    gpio_alternate_function_mux dut (.CLK_SYS_I(clk), .NRST_I(nrst), .PACKAGE_SEL_I(pkg_sel),
        .HAS_ADC_I(has_adc), .CFG_WR_I(wr), .CFG_A_I(cfg_a), .CFG_B_I(cfg_b), .CFG_C_I(cfg_c),
        .PERIPH_I(per), .PIN_A_IN_I(pin_lvl[7:0]), .PIN_B_IN_I(pin_lvl[15:8]),
        .PIN_C_IN_I(pin_lvl[23:16]), .PIN_A_OUT_O(pout[7:0]), .PIN_A_OE_O(poe[7:0]),
        .PIN_B_OUT_O(pout[15:8]), .PIN_B_OE_O(poe[15:8]), .PIN_C_OUT_O(pout[23:16]),
        .PIN_C_OE_O(poe[23:16]), .PULL_UP_A_O(ppu[7:0]), .PULL_UP_B_O(ppu[15:8]),
        .PULL_UP_C_O(ppu[23:16]), .LED_DRIVE_C_O(led), .WAKE_CHANGE_O(wake), .ANALOG_A_O(ana),
        .PORT_A_DATA_O(pdat[7:0]), .PORT_B_DATA_O(pdat[15:8]), .PORT_C_DATA_O(pdat[23:16]),
        .PERIPH_O(fn_in));

    periph_board_model partner (.phase_i(phase), .tmode_i(tmode), .xtal_i(xtal),
        .out_i(pout), .oe_i(poe), .pu_i(ppu), .per_o(per), .pin_o(pin_lvl));

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : final_report

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic wr_cfg(input logic [2:0] m, input pin_mux_pkg::port_cfg_s c);
        @(posedge clk);
        wr <= m;
        cfg_a <= c;
        cfg_b <= c;
        cfg_c <= c;
        @(posedge clk);
        wr <= 3'h0;
        tick(2);
    endtask : wr_cfg

    task automatic do_reset(input logic [1:0] pk, input logic adc);
        @(posedge clk);
        nrst <= 1'b0;
        pkg_sel <= pk;
        has_adc <= adc;
        tick(5);
        check("reset oe", poe[15:0], 16'h0000);
        check("reset periph", 16'(fn_in), 16'h0000);
        @(posedge clk);
        nrst <= 1'b1;
        tick(2);
    endtask : do_reset

    // Plain port mode, pull-ups and crystal override on an 8-pin part
    task automatic t_gpio();
        pin_mux_pkg::port_cfg_s c;
        c = '0;
        c.out_data = 8'h2a;
        c.pull_up = 8'h15;
        c.alt_select_low = 8'hff;
        c.alt_select_high = 8'hff;
        wr_cfg(3'h1, c);
        check("gpio oe", poe[7:0], 8'h3f);
        check("gpio out", pout[7:0], 8'h2a);
        check("pull up", ppu[7:0], 8'h15);
        check("port a data", pdat[7:0], 8'h2a);
        @(posedge clk);
        xtal <= 1'b1;
        tick(2);
        check("xtal oe", poe[7:0], 8'h3c);
        @(posedge clk);
        xtal <= 1'b0;
        c.dir_in = 8'hff;
        c.pull_up = 8'h00;
        c.wake_en = 8'h01;
        wr_cfg(3'h1, c);
        @(posedge clk);
        phase <= 1'b1;
        tick(1);
        check("wake pulse", wake, 8'h01);
        tick(1);
        check("wake end", wake, 8'h00);
    endtask : t_gpio

    // Twenty select codes of the six 8-pin port A pins: pin, code lo/hi, kind, source
    task automatic t_alt();
        logic [15:0] tbl [20];
        pin_mux_pkg::port_cfg_s c;
        logic [3:0] p;
        logic [3:0] k;
        logic [3:0] s;
        tbl = '{16'h0000, 16'h0310, 16'h0120, 16'h1011, 16'h1201, 16'h1330, 16'h2012,
            16'h2102, 16'h2213, 16'h3003, 16'h3114, 16'h3204, 16'h3330, 16'h4005,
            16'h4220, 16'h4330, 16'h5015, 16'h5116, 16'h5220, 16'h5330};
        foreach (tbl[i])
        begin
            p = tbl[i][15:12];
            k = tbl[i][7:4];
            s = tbl[i][3:0];
            c = '0;
            c.dir_in = 8'hff;
            c.alt_select_low[p] = tbl[i][9];
            c.alt_select_high[p] = tbl[i][8];
            tmode <= (p == 4'h0 && k == 4'h0);
            wr_cfg(3'h1, c);
            c.alt_function_enable[p] = 1'b1;
            wr_cfg(3'h1, c);
            for (int ph = 0; ph < 2; ph++)
            begin
                @(posedge clk);
                phase <= ph[0];
                tick(2);
                check("alt oe", poe[p], k == 4'h1);
                if (k == 4'h1)
                    check("alt out", pout[p], fsrc[s]);
                if (k == 4'h0)
                    check("alt in", isrc[s], pin_lvl[p]);
                if (k == 4'h3)
                    check("analog", ana[p], 1'b1);
            end
        end
    endtask : t_alt

    // Pin sets and port C drive of the larger packages
    task automatic t_pkg();
        pin_mux_pkg::port_cfg_s c;
        for (int i = 0; i < 2; i++)
        begin
            do_reset(i ? pin_mux_pkg::PKG_28PIN : pin_mux_pkg::PKG_20PIN, i[0]);
            c = '0;
            c.drive = 16'h9c39;
            c.out_data = 8'hc3;
            c.pull_up = 8'hff;
            wr_cfg(3'h7, c);
            check("pull up bc", ppu[23:8], i ? 16'hff3f : 16'h0f0f);
            check("pin bc out", pout[23:8], i ? 16'hc303 : 16'h0303);
            check("port bc data", pdat[23:8], i ? 16'hc303 : 16'h0303);
            check("oe a", poe[7:0], 8'hff);
            check("oe b", poe[15:8], i ? 8'h3f : 8'h0f);
            check("oe c", poe[23:16], i ? 8'hff : 8'h0f);
            check("led drive", led, i ? 16'h9c39 : 16'h0039);
        end
    endtask : t_pkg

    initial
    begin
        nrst = 1'b0;
        wr = 3'h0;
        phase = 1'b0;
        tmode = 1'b0;
        xtal = 1'b0;
        pkg_sel = pin_mux_pkg::PKG_8PIN;
        has_adc = 1'b0;
        cfg_a = '0;
        cfg_b = '0;
        cfg_c = '0;
        do_reset(pin_mux_pkg::PKG_8PIN, 1'b1);
        t_gpio();
        t_alt();
        t_pkg();
        final_report();
    end

    initial
    begin
        #2000000;
        bad_count++;
        final_report();
    end
endmodule : tb_top
`default_nettype wire
